// ---- hw/wgsc_deadband.sv ----
// rising-edge delay unit: output rises count+1 clocks after input, falls one clock after input falls
`timescale 1ns/1ns
module wgsc_deadband (
  input  wire logic clk,       // generator clock
  input  wire logic rst,       // async reset, high
  wgsc_db_if.unit   db         // level in, count, delayed level out
);
  logic [5:0] cnt_reg;
  logic       out_reg;

  assign db.sig_out = out_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 6'h00;
      out_reg <= 1'b0;
    end
    else if (!db.sig_in)
    begin
      cnt_reg <= 6'h00;
      out_reg <= 1'b0;
    end
    else if (cnt_reg == db.count)
      out_reg <= 1'b1;
    else
      cnt_reg <= cnt_reg + 6'h01;
  end

  property p_db_low;
    @(posedge clk) disable iff (rst) !db.sig_in |=> !db.sig_out;
  endproperty
  a_db_low: assert property (p_db_low) else $error("dead-band output high after input low");
endmodule

// ---- hw/wgsc_sync.sv ----
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module wgsc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // generator clock
  input  wire logic         rst,   // async reset, high
  input  wire logic [W-1:0] d,     // asynchronous level
  output logic      [W-1:0] q      // synchronised level
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ---- hw/wgsc_top.sv ----
// waveform generator control, shutdown and restart with AXI4-Lite registers
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "wgsc_defines.svh"
module wgsc_top (
  input  wire logic        CLK,           // generator clock, 25 MHz
  input  wire logic        SYS_RST,       // async reset, high
  input  wire logic [7:0]  S_AXI_AWADDR,  // write address
  input  wire logic        S_AXI_AWVALID, // write address valid
  output logic             S_AXI_AWREADY, // write address ready
  input  wire logic [31:0] S_AXI_WDATA,   // write data
  input  wire logic [3:0]  S_AXI_WSTRB,   // write byte lanes
  input  wire logic        S_AXI_WVALID,  // write data valid
  output logic             S_AXI_WREADY,  // write data ready
  output logic [1:0]       S_AXI_BRESP,   // write response
  output logic             S_AXI_BVALID,  // write response valid
  input  wire logic        S_AXI_BREADY,  // write response ready
  input  wire logic [7:0]  S_AXI_ARADDR,  // read address
  input  wire logic        S_AXI_ARVALID, // read address valid
  output logic             S_AXI_ARREADY, // read address ready
  output logic [31:0]      S_AXI_RDATA,   // read data
  output logic [1:0]       S_AXI_RRESP,   // read response
  output logic             S_AXI_RVALID,  // read data valid
  input  wire logic        S_AXI_RREADY,  // read data ready
  input  wire logic        WG_IN,         // waveform input pin
  input  wire logic [3:0]  SHDN_IN_N,     // shutdown inputs, active low
  output logic             OUT_A,         // output a
  output logic             OUT_B,         // output b
  output logic             OUT_C,         // output c
  output logic             OUT_D          // output d
);
  wgsc_pkg::wgsc_state_t state_reg;
  wgsc_pkg::wgsc_state_t state_next;
  logic [7:0]  aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic        w_strb_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [7:0]  rd_val;
  logic        rd_hit;
  logic        wr_hit;
  logic        en_reg;
  logic        ld_reg;
  logic [2:0]  mode_reg;
  logic [3:0]  pol_reg;
  logic [5:0]  dbr_reg;
  logic [5:0]  dbf_reg;
  logic [5:0]  dbr_act_reg;
  logic [5:0]  dbf_act_reg;
  logic        sd_reg;
  logic        ren_reg;
  logic [1:0]  override_level_pair_two_reg;
  logic [1:0]  override_level_pair_one_reg;
  logic [3:0]  src_reg;
  logic [3:0]  steer_reg;
  logic [3:0]  steer_act_reg;
  logic        phase_reg;
  logic        in_d_reg;
  logic [4:0]  pins_s;
  logic        in_s;
  logic        in_rise;
  logic        in_edge;
  logic        fault_any;
  logic        wr_go;
  logic        wr_main;
  logic        wr_sdc;
  logic [3:0]  wave;
  logic [3:0]  out_next;

  wgsc_db_if db_r ();
  wgsc_db_if db_f ();

  wgsc_sync #(.W(5)) u_sync (
    .clk (CLK),
    .rst (SYS_RST),
    .d   ({WG_IN, SHDN_IN_N}),
    .q   (pins_s)
  );
  wgsc_deadband u_db_rise (
    .clk (CLK),
    .rst (SYS_RST),
    .db  (db_r.unit)
  );
  wgsc_deadband u_db_fall (
    .clk (CLK),
    .rst (SYS_RST),
    .db  (db_f.unit)
  );

  assign in_s          = pins_s[4];
  assign in_rise       = in_s & ~in_d_reg;
  assign in_edge       = in_s ^ in_d_reg;
  assign fault_any     = |(src_reg & ~pins_s[3:0]);
  assign db_r.sig_in   = in_s;
  assign db_r.count    = dbr_act_reg;
  assign db_f.sig_in   = ~in_s;
  assign db_f.count    = dbf_act_reg;
  assign wr_go         = aw_have_reg & w_have_reg & ~S_AXI_BVALID;
  assign wr_main       = wr_go & w_strb_reg & (aw_addr_reg == `WGSC_OFF_MAIN);
  assign wr_sdc        = wr_go & w_strb_reg & (aw_addr_reg == `WGSC_OFF_SDC);

  // write channel: address and data taken in either order, answered once both held
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `WGSC_RESP_OKAY;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 8'h00;
      w_strb_reg    <= 1'b0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_addr_reg   <= S_AXI_AWADDR;
        aw_have_reg   <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_data_reg   <= S_AXI_WDATA[7:0];
        w_strb_reg   <= S_AXI_WSTRB[0];
        w_have_reg   <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? `WGSC_RESP_OKAY : `WGSC_RESP_SLV;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always_comb
  begin
    wr_hit = 1'b1;
    case (aw_addr_reg)
      `WGSC_OFF_MAIN, `WGSC_OFF_POL, `WGSC_OFF_DBR, `WGSC_OFF_DBF,
      `WGSC_OFF_SDC, `WGSC_OFF_SRC, `WGSC_OFF_STEER: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    rd_hit = 1'b1;
    case (S_AXI_ARADDR)
      `WGSC_OFF_MAIN:  rd_val = {en_reg, ld_reg, 3'h0, mode_reg};
      `WGSC_OFF_POL:   rd_val = {2'h0, in_s, 1'b0, pol_reg};
      `WGSC_OFF_DBR:   rd_val = {2'h0, dbr_reg};
      `WGSC_OFF_DBF:   rd_val = {2'h0, dbf_reg};
      `WGSC_OFF_SDC:   rd_val = {sd_reg, ren_reg, override_level_pair_two_reg, override_level_pair_one_reg, 2'h0};
      `WGSC_OFF_SRC:   rd_val = {4'h0, src_reg};
      `WGSC_OFF_STEER: rd_val = {4'h0, steer_reg};
      default:
      begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `WGSC_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= {24'h000000, rd_val};
      S_AXI_RRESP   <= rd_hit ? `WGSC_RESP_OKAY : `WGSC_RESP_SLV;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // main control
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      en_reg   <= 1'b0;
      mode_reg <= `WGSC_RST_MODE;
    end
    else if (wr_main)
    begin
      en_reg   <= w_data_reg[`WGSC_EN_BIT];
      mode_reg <= w_data_reg[2:0];
    end
  end

  // load request: set needs enable already on, set beats the edge clear
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      ld_reg <= 1'b0;
    else if (wr_main && w_data_reg[`WGSC_LD_BIT] && en_reg && w_data_reg[`WGSC_EN_BIT])
      ld_reg <= 1'b1;
    else if (!en_reg || in_edge)
      ld_reg <= 1'b0;
  end

  // software copies of dead band and the other settings
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pol_reg   <= `WGSC_RST_NIB;
      dbr_reg   <= `WGSC_RST_DB;
      dbf_reg   <= `WGSC_RST_DB;
      ren_reg   <= 1'b0;
      override_level_pair_two_reg  <= `WGSC_RST_LVL;
      override_level_pair_one_reg  <= `WGSC_RST_LVL;
      src_reg   <= `WGSC_RST_NIB;
      steer_reg <= `WGSC_RST_NIB;
    end
    else if (wr_go && w_strb_reg)
    begin
      case (aw_addr_reg)
        `WGSC_OFF_POL:   pol_reg <= w_data_reg[3:0];
        `WGSC_OFF_DBR:   dbr_reg <= w_data_reg[5:0];
        `WGSC_OFF_DBF:   dbf_reg <= w_data_reg[5:0];
        `WGSC_OFF_SDC:
        begin
          ren_reg  <= w_data_reg[`WGSC_REN_BIT];
          override_level_pair_two_reg <= w_data_reg[5:4];
          override_level_pair_one_reg <= w_data_reg[3:2];
        end
        `WGSC_OFF_SRC:   src_reg <= w_data_reg[3:0];
        `WGSC_OFF_STEER: steer_reg <= w_data_reg[3:0];
        default: ;
      endcase
    end
  end

  // active dead band: follows at once while disabled, at an input edge with a load request pending when enabled
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      dbr_act_reg <= `WGSC_RST_DB;
      dbf_act_reg <= `WGSC_RST_DB;
    end
    else if (!en_reg || (ld_reg && in_edge))
    begin
      dbr_act_reg <= dbr_reg;
      dbf_act_reg <= dbf_reg;
    end
  end

  // shutdown bit: an active selected input always wins over any clear
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      sd_reg <= 1'b0;
    else if (fault_any)
      sd_reg <= 1'b1;
    else if (wr_sdc)
      sd_reg <= w_data_reg[`WGSC_SD_BIT];
    else if (ren_reg)
      sd_reg <= 1'b0;
  end

  // override until the first rising input edge after shutdown clears
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      wgsc_pkg::WGSC_SHUT:
        if (!sd_reg && !fault_any)
          state_next = wgsc_pkg::WGSC_ARM;
      wgsc_pkg::WGSC_ARM:
        if (sd_reg || fault_any)
          state_next = wgsc_pkg::WGSC_SHUT;
        else if (in_rise)
          state_next = wgsc_pkg::WGSC_RUN;
      wgsc_pkg::WGSC_RUN:
        if (sd_reg || fault_any)
          state_next = wgsc_pkg::WGSC_SHUT;
      default: state_next = wgsc_pkg::WGSC_SHUT;
    endcase
    if (!en_reg)
      state_next = wgsc_pkg::WGSC_SHUT;
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      state_reg <= wgsc_pkg::WGSC_SHUT;
    else
      state_reg <= state_next;
  end

  // input history, push-pull phase and synchronous steering copy
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      in_d_reg      <= 1'b0;
      phase_reg     <= 1'b0;
      steer_act_reg <= `WGSC_RST_NIB;
    end
    else
    begin
      in_d_reg <= in_s;
      if (in_rise)
      begin
        phase_reg     <= ~phase_reg;
        steer_act_reg <= steer_reg;
      end
    end
  end

  // normal waveform per mode, ordered {d, c, b, a}
  always_comb
  begin
    case (mode_reg)
      wgsc_pkg::WGSC_M_STEER:  wave = steer_reg & {4{in_s}};
      wgsc_pkg::WGSC_M_SSTEER: wave = steer_act_reg & {4{in_s}};
      wgsc_pkg::WGSC_M_FWD:    wave = {in_s, 1'b0, 1'b0, 1'b1};
      wgsc_pkg::WGSC_M_REV:    wave = {1'b0, 1'b1, in_s, 1'b0};
      wgsc_pkg::WGSC_M_HALF:   wave = {db_f.sig_out, db_r.sig_out, db_f.sig_out, db_r.sig_out};
      wgsc_pkg::WGSC_M_PUSH:
        wave = {in_s & ~phase_reg, in_s & phase_reg, in_s & ~phase_reg, in_s & phase_reg};
      default: wave = 4'h0;
    endcase
    if (!en_reg)
      out_next = 4'h0;
    else if (state_reg != wgsc_pkg::WGSC_RUN)
      out_next = {override_level_pair_two_reg[1], override_level_pair_one_reg[1], override_level_pair_two_reg[0], override_level_pair_one_reg[0]};
    else
      out_next = wave ^ pol_reg;
  end

  // outputs from flops; a disabled generator drives low
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      OUT_A <= 1'b0;
      OUT_B <= 1'b0;
      OUT_C <= 1'b0;
      OUT_D <= 1'b0;
    end
    else
    begin
      OUT_A <= out_next[0];
      OUT_B <= out_next[1];
      OUT_C <= out_next[2];
      OUT_D <= out_next[3];
    end
  end

  property p_ovr_ac;
    @(posedge CLK) disable iff (SYS_RST)
      (en_reg && state_reg != wgsc_pkg::WGSC_RUN) |=> (OUT_A == $past(override_level_pair_one_reg[0]) && OUT_C == $past(override_level_pair_one_reg[1]));
  endproperty
  a_ovr_ac: assert property (p_ovr_ac) else $error("a/c not at override level");

  property p_ovr_pol;
    @(posedge CLK) disable iff (SYS_RST)
      (en_reg && state_reg == wgsc_pkg::WGSC_SHUT && pol_reg != 4'h0)
        |=> (OUT_B == $past(override_level_pair_two_reg[0]) && OUT_D == $past(override_level_pair_two_reg[1]));
  endproperty
  a_ovr_pol: assert property (p_ovr_pol) else $error("polarity changed an override");

  property p_sw_clear;
    @(posedge CLK) disable iff (SYS_RST) (sd_reg && fault_any) |=> sd_reg;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("shutdown cleared with input active");

  property p_hold_edge;
    @(posedge CLK) disable iff (SYS_RST)
      (state_reg == wgsc_pkg::WGSC_ARM && !in_rise) |=> state_reg != wgsc_pkg::WGSC_RUN;
  endproperty
  a_hold_edge: assert property (p_hold_edge) else $error("resumed without rising edge");

  property p_auto;
    @(posedge CLK) disable iff (SYS_RST) (ren_reg && sd_reg && !fault_any && !wr_sdc) |=> !sd_reg;
  endproperty
  a_auto: assert property (p_auto) else $error("auto-restart did not clear shutdown");

  property p_ld_clear;
    @(posedge CLK) disable iff (SYS_RST) (ld_reg && in_edge && !wr_main) |=> !ld_reg;
  endproperty
  a_ld_clear: assert property (p_ld_clear) else $error("load request not cleared at edge");

  property p_ld_en;
    @(posedge CLK) disable iff (SYS_RST) (!en_reg && !ld_reg) |=> !ld_reg;
  endproperty
  a_ld_en: assert property (p_ld_en) else $error("load request set while disabled");

  property p_rsvd;
    @(posedge CLK) disable iff (SYS_RST)
      (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `WGSC_OFF_MAIN) |=> S_AXI_RDATA[5:3] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("unimplemented bits read nonzero");

  property p_sw_shut;
    @(posedge CLK) disable iff (SYS_RST) sd_reg |=> state_reg == wgsc_pkg::WGSC_SHUT;
  endproperty
  a_sw_shut: assert property (p_sw_shut) else $error("shutdown bit set but not in shutdown");
endmodule

// ---- inc/wgsc_db_if.sv ----
// connection between the generator and one dead-band delay unit
`timescale 1ns/1ns
interface wgsc_db_if;
  logic       sig_in;
  logic [5:0] count;
  logic       sig_out;
  modport ctrl (output sig_in, output count, input sig_out);
  modport unit (input sig_in, input count, output sig_out);
endinterface

// ---- inc/wgsc_defines.svh ----
// register offsets, field positions, reset values and response codes
`ifndef WGSC_DEFINES_SVH
`define WGSC_DEFINES_SVH
`define WGSC_OFF_MAIN   8'h00
`define WGSC_OFF_POL    8'h04
`define WGSC_OFF_DBR    8'h08
`define WGSC_OFF_DBF    8'h0C
`define WGSC_OFF_SDC    8'h10
`define WGSC_OFF_SRC    8'h14
`define WGSC_OFF_STEER  8'h18
`define WGSC_EN_BIT     7
`define WGSC_LD_BIT     6
`define WGSC_SD_BIT     7
`define WGSC_REN_BIT    6
`define WGSC_IN_BIT     5
`define WGSC_RST_MODE   3'h0
`define WGSC_RST_NIB    4'h0
`define WGSC_RST_DB     6'h00
`define WGSC_RST_LVL    2'h0
`define WGSC_RESP_OKAY  2'h0
`define WGSC_RESP_SLV   2'h2
`endif

// ---- inc/wgsc_pkg.sv ----
// shared types of the waveform generator shutdown control
package wgsc_pkg;
  typedef enum logic [1:0] {
    WGSC_SHUT = 2'h0,
    WGSC_ARM  = 2'h1,
    WGSC_RUN  = 2'h3
  } wgsc_state_t;
  typedef enum logic [2:0] {
    WGSC_M_STEER = 3'h0,
    WGSC_M_SSTEER = 3'h1,
    WGSC_M_FWD   = 3'h2,
    WGSC_M_REV   = 3'h3,
    WGSC_M_HALF  = 3'h4,
    WGSC_M_PUSH  = 3'h5
  } wgsc_mode_t;
endpackage

// ---- verif/tb_top.sv ----
// self-checking bench: register access, shutdown and restart behaviour
`timescale 1ns/1ns
module tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        wg_in = 1'b0, fault = 1'b0;
  logic [2:0]  noise = 3'h0;
  logic [3:0]  shdn_n;
  logic        out_a, out_b, out_c, out_d;
  logic [33:0] e_r;
  logic [33:0] rexp_q[$];
  logic [1:0]  bexp_q[$];
  logic [7:0]  rnd6;
  int          fails = 0;
  int          samples_checked = 0;

  always #20 clk = ~clk;
  // unselected fault lines chatter to show that selection masks them
  always @(posedge clk) noise <= 3'($urandom());

  wgsc_top u_dut (.CLK(clk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .WG_IN(wg_in),
    .SHDN_IN_N(shdn_n), .OUT_A(out_a), .OUT_B(out_b), .OUT_C(out_c), .OUT_D(out_d));

  wgsc_bridge_model u_stage (.CLK(clk), .fault(fault), .noise(noise),
    .legs({out_d, out_c, out_b, out_a}), .shdn_n(shdn_n), .short_seen());

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic [31:0] rnd;
    rnd = $urandom();
    @(posedge clk);
    bexp_q.push_back(r);
    awaddr <= a;
    wdata <= {rnd[31:8], d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        bready <= 1'b0;
        return;
      end
    end
    fails++;
    stop_test();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk);
    rexp_q.push_back({r, 24'h000000, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        rready <= 1'b0;
        return;
      end
    end
    fails++;
    stop_test();
  endtask

  // pins are compared a settled number of cycles after the last stimulus
  task automatic pins(input int cyc, input logic [3:0] e);
    repeat (cyc) @(posedge clk);
    check("pins", {28'h0, out_d, out_c, out_b, out_a}, {28'h0, e});
  endtask

  task automatic pulse_in;
    @(posedge clk);
    wg_in <= 1'b0;
    repeat (6) @(posedge clk);
    wg_in <= 1'b1;
  endtask

  // results are compared in arrival order against the notes left by the drivers
  always @(posedge clk)
  begin
    if (rvalid && rready)
    begin
      e_r = rexp_q.pop_front();
      check("rresp", {30'h0, rresp}, {30'h0, e_r[33:32]});
      check("rdata", rdata, e_r[31:0]);
    end
    if (bvalid && bready) check("bresp", {30'h0, bresp}, {30'h0, bexp_q.pop_front()});
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end

  initial
  begin
    void'($urandom(32'h43899674));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h00, 8'h00, 2'h0);
    rd(8'h1C, 8'h00, 2'h2);
    wr(8'h20, 8'h55, 2'h2);
    wr(8'h00, 8'h7D, 2'h0);
    rd(8'h00, 8'h05, 2'h0);
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h00, 8'(m), 2'h0);
      rd(8'h00, 8'(m), 2'h0);
    end
    rnd6 = 8'($urandom_range(63));
    wr(8'h08, rnd6, 2'h0);
    rd(8'h08, rnd6, 2'h0);
    // setup with enable cleared, polarity inverted on a and b only
    // a half-bridge never shows all four legs high with this polarity, so the stage sees no short
    wr(8'h00, 8'h04, 2'h0);
    wr(8'h04, 8'h03, 2'h0);
    wr(8'h10, 8'hA4, 2'h0);
    wr(8'h14, 8'h01, 2'h0);
    wr(8'h00, 8'hC4, 2'h0);
    rd(8'h00, 8'h84, 2'h0);
    pins(6, 4'h9);
    wr(8'h00, 8'hC4, 2'h0);
    rd(8'h00, 8'hC4, 2'h0);
    @(posedge clk);
    wg_in <= 1'b1;
    repeat (6) @(posedge clk);
    rd(8'h00, 8'h84, 2'h0);
    pins(2, 4'h9);
    // software restart refused while a selected fault is active
    fault <= 1'b1;
    repeat (6) @(posedge clk);
    wr(8'h10, 8'h24, 2'h0);
    rd(8'h10, 8'hA4, 2'h0);
    fault <= 1'b0;
    repeat (6) @(posedge clk);
    wr(8'h10, 8'h24, 2'h0);
    rd(8'h10, 8'h24, 2'h0);
    pins(8, 4'h9);
    pulse_in();
    // wait covers the longest rising dead band before comparing
    pins(70, 4'h6);
    // automatic restart
    fault <= 1'b1;
    pins(6, 4'h9);
    wr(8'h10, 8'h64, 2'h0);
    rd(8'h10, 8'hE4, 2'h0);
    fault <= 1'b0;
    repeat (8) @(posedge clk);
    rd(8'h10, 8'h64, 2'h0);
    pins(4, 4'h9);
    pulse_in();
    pins(70, 4'h6);
    // software shutdown holds through input edges
    wr(8'h10, 8'hA4, 2'h0);
    pins(4, 4'h9);
    pulse_in();
    pins(10, 4'h9);
    rd(8'h10, 8'hA4, 2'h0);
    rd(8'h04, 8'h23, 2'h0);
    wr(8'h00, 8'h04, 2'h0);
    pins(6, 4'h0);
    rd(8'h00, 8'h04, 2'h0);
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule

// ---- verif/wgsc_bridge_model.sv ----
// power stage model: fault sensing that feeds the shutdown lines
`timescale 1ns/1ns
module wgsc_bridge_model (
  input  wire logic       CLK,    // generator clock
  input  wire logic       fault,  // overcurrent reported by the stage
  input  wire logic [2:0] noise,  // activity on lines left unselected
  input  wire logic [3:0] legs,   // gate drives d,c,b,a
  output logic      [3:0] shdn_n, // fault lines, open drain with pull-up
  output logic            short_seen // every gate on at once
);
  // fault stays low as a level for as long as the condition lasts
  always_comb shdn_n = {noise, ~(fault | short_seen)};
  // every gate on at once reports a fault for as long as it lasts
  always_ff @(posedge CLK)
    short_seen <= (legs == 4'hF);
endmodule
